// File: fpm_dram_ctrl.sv
/*
  Fast page mode DRAM sequencer for two banks with bus arbitration and an
  Avalon-MM register slave. Assumes core requests are held until acknowledged
  and the DRAM data bus is resolved outside from dram_data_oe.
*/
// Chosen here: the register offsets and the Avalon-MM slave port.
module fpm_dram_ctrl
  import fpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Core transfer request
  input wire fpm_req_s core_req,
  output logic transfer_ack,
  output logic [31:0] core_rdata,
  // Arbitration and system
  input wire logic bus_grant_n,
  input wire logic nondram_busy,
  input wire logic refresh_pend,
  output logic bus_driven_n,
  // DRAM pins
  output logic [ADDR_W-1:0] dram_addr,
  output logic [1:0] ras_n,
  output logic [3:0] cas_n,
  output logic dram_write_n,
  output logic [1:0] transfer_size,
  output logic transfer_start_n,
  output logic [31:0] dram_data_out,
  output logic dram_data_oe,
  input wire logic [31:0] dram_data_in
);
  fpm_state_e st_q, state_d;
  fpm_cfg_s cfg_q;
  logic wait_q;
  logic [1:0] open_q, ras_on_q, ras_neg_q, close_mask, ras_zero;
  logic [3:0] cas_on_q, cas_neg_q;
  logic [ROW_W-1:0] row_q [2];
  logic [CNT_W-1:0] wcnt_q;
  logic lock_held_q, lost, own, hit, go, cas_zero, ack_exit, b;
  logic [ROW_W-1:0] pmask;

  // Register slave: one wait cycle, then answer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end
  assign avs_waitrequest = wait_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && wait_q) begin
      case (avs_address)
        REG_CTRL_OFS: avs_readdata <= 32'(cfg_q[2:0]);
        REG_TIMING_OFS: avs_readdata <= 32'(cfg_q[3*CNT_W+2:3]);
        REG_STATUS_OFS: avs_readdata <= 32'({st_q != ST_IDLE, lock_held_q,
                                              bus_driven_n, open_q});
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= '{WAIT_CLK_DEF, CAS_GAP_CLK_DEF, RAS_PRE_CLK_DEF, PSIZE_DEF, 1'b0};
    end else if (avs_write && !wait_q) begin
      if (avs_address == REG_CTRL_OFS) begin
        cfg_q.bus_lock_bit <= avs_writedata[CTRL_LOCK_POS];
        cfg_q.page_size_code <= avs_writedata[CTRL_PSIZE_POS +: 2];
      end else if (avs_address == REG_TIMING_OFS) begin
        cfg_q.ras_pre <= avs_writedata[TIM_RAS_POS +: CNT_W];
        cfg_q.cas_gap <= avs_writedata[TIM_CAS_POS +: CNT_W];
        cfg_q.wait_clk <= avs_writedata[TIM_WAIT_POS +: CNT_W];
      end
    end
  end

  // Arbitration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_held_q <= 1'b0;
    end else if (!cfg_q.bus_lock_bit) begin
      lock_held_q <= 1'b0;
    end else if (!bus_grant_n) begin
      lock_held_q <= 1'b1;
    end
  end
  assign lost = bus_grant_n && !lock_held_q;
  assign own = !bus_driven_n && !lost;
  assign ack_exit = (st_q == ST_ACK);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_driven_n <= 1'b1;
    end else if (bus_driven_n) begin
      bus_driven_n <= bus_grant_n;
    end else if (lost && st_q == ST_IDLE && !nondram_busy) begin
      bus_driven_n <= 1'b1;
    end else if (lost && (ack_exit || st_q == ST_PRE)) begin
      bus_driven_n <= 1'b1;
    end
  end

  // Page hit compare per page-size code
  assign b = core_req.bank;
  assign pmask = {ROW_W{1'b1}} << ((cfg_q.page_size_code == 2'h3) ? 2'h2
                                   : cfg_q.page_size_code);
  assign hit = open_q[b] && (((core_req.addr[31:9] ^ row_q[b]) & pmask) == '0);
  assign go = core_req.req && own && !refresh_pend && cas_zero;

  // Sequencer
  always_comb begin
    state_d = st_q;
    close_mask = 2'b00;
    case (st_q)
      ST_IDLE: begin
        if (refresh_pend || (lost && !bus_driven_n)) begin
          close_mask = 2'b11;
        end else if (go && hit) begin
          // Same path whatever opened the page
          state_d = core_req.seq ? ST_COL : ST_HIT;
        end else if (go && open_q[b]) begin
          close_mask[b] = 1'b1;
          state_d = ST_PRE;
        end else if (go && ras_zero[b]) begin
          close_mask[!b] = 1'b1;
          state_d = ST_ROW;
        end
      end
      ST_PRE: begin
        if (lost) begin
          state_d = ST_IDLE;
        end else if (ras_zero[b]) begin
          state_d = ST_ROW;
        end
      end
      ST_ROW: state_d = ST_COL;
      ST_HIT: state_d = core_req.write ? ST_COL : ST_ACK;
      ST_COL: state_d = (wcnt_q == '0) ? ST_ACK : ST_COL;
      ST_ACK: begin
        state_d = ST_IDLE;
        if (lost || core_req.ext) begin
          close_mask = 2'b11;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= state_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wcnt_q <= '0;
    end else if (state_d == ST_COL && st_q != ST_COL) begin
      wcnt_q <= cfg_q.wait_clk;
    end else if (wcnt_q != '0) begin
      wcnt_q <= wcnt_q - 1'b1;
    end
  end

  // Per-bank open page and row strobe
  for (genvar i = 0; i < 2; i++) begin : g_bank
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        open_q[i] <= 1'b0;
        ras_on_q[i] <= 1'b0;
        row_q[i] <= '0;
      end else if (close_mask[i]) begin
        open_q[i] <= 1'b0;
        ras_on_q[i] <= 1'b0;
      end else if (state_d == ST_ROW && b == 1'(i)) begin
        open_q[i] <= 1'b1;
        ras_on_q[i] <= 1'b1;
        row_q[i] <= core_req.addr[31:9];
      end
    end
    fpm_pre_cnt #(.W(CNT_W)) u_ras_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .load(close_mask[i] && open_q[i]),
      .val((cfg_q.ras_pre == '0) ? '0 : cfg_q.ras_pre - 1'b1),
      .zero(ras_zero[i])
    );
  end

  fpm_pre_cnt #(.W(CNT_W)) u_cas_cnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(ack_exit),
    .val(((cfg_q.cas_gap < CAS_GAP_CLK_MIN) ? CAS_GAP_CLK_MIN : cfg_q.cas_gap) - 1'b1),
    .zero(cas_zero)
  );

  // Pin drive on the rising edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      transfer_start_n <= 1'b1;
      dram_addr <= '0;
      dram_write_n <= 1'b1;
      transfer_size <= SIZE_LONG;
      cas_on_q <= 4'h0;
      transfer_ack <= 1'b0;
    end else begin
      transfer_start_n <= !(state_d == ST_ROW || state_d == ST_HIT);
      dram_addr <= (state_d == ST_ROW) ? core_req.addr[27:9]
                   : ADDR_W'(core_req.addr[10:0]);
      if (state_d == ST_ROW || state_d == ST_HIT) begin
        dram_write_n <= !core_req.write;
        transfer_size <= core_req.size;
      end
      if ((state_d == ST_HIT && !core_req.write) || state_d == ST_COL
          || state_d == ST_ACK) begin
        cas_on_q <= core_req.lanes;
      end else begin
        cas_on_q <= 4'h0;
      end
      transfer_ack <= (state_d == ST_ACK);
    end
  end

  // Write data from the cycle after start; reads leave the bus to the DRAM
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dram_data_oe <= 1'b0;
      dram_data_out <= 32'h0000_0000;
    end else begin
      dram_data_oe <= core_req.write && (state_d == ST_COL || state_d == ST_ACK);
      dram_data_out <= core_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_rdata <= 32'h0000_0000;
    end else if (ack_exit && !core_req.write) begin
      core_rdata <= dram_data_in;
    end
  end

  // Strobes assert in the low phase, release on the rising edge
  always_ff @(negedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ras_neg_q <= 2'b00;
      cas_neg_q <= 4'h0;
    end else begin
      ras_neg_q <= ras_on_q;
      cas_neg_q <= cas_on_q;
    end
  end
  assign ras_n = ~(ras_on_q & ras_neg_q);
  assign cas_n = ~(cas_on_q & cas_neg_q);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_ack_end;
    st_q == ST_ACK && close_mask == 2'b00;
  endsequence
  sequence s_hit_wr;
    st_q == ST_HIT && core_req.write && cfg_q.wait_clk == '0;
  endsequence

  a_page_kept_open: assert property (s_ack_end |=> ras_on_q[$past(b)]
    && cas_on_q == 4'h0 && !transfer_ack) else $error("row strobe dropped at end");
  a_hit_read_cas: assert property (st_q == ST_HIT && !core_req.write |->
    cas_on_q != 4'h0 && !transfer_start_n) else $error("hit read strobe late");
  a_read_data_reg: assert property (transfer_ack && !core_req.write |=>
    core_rdata == $past(dram_data_in)) else $error("read data not registered");
  a_hit_write_late: assert property (st_q == ST_HIT && core_req.write |->
    cas_on_q == 4'h0 && !dram_data_oe ##1 dram_data_oe) else $error("write strobe early");
  a_hit_write_len: assert property (s_hit_wr |-> !transfer_ack ##1 !transfer_ack
    ##1 transfer_ack) else $error("hit write not three clocks");
  a_cas_gap_min: assert property (st_q == ST_ACK |=> transfer_start_n[*2])
    else $error("start too soon after strobe release");
  a_bus_release: assert property (st_q == ST_ACK |=> !dram_data_oe)
    else $error("data bus still driven");
  a_miss_precharge: assert property (st_q == ST_PRE |-> !ras_on_q[b])
    else $error("row strobe on in precharge");
  a_miss_row_start: assert property (st_q == ST_ROW |-> !transfer_start_n
    && dram_addr == core_req.addr[27:9]) else $error("row start wrong");
  a_lost_in_xfer: assert property (st_q == ST_ACK && lost && !bus_driven_n |->
    !bus_driven_n ##1 bus_driven_n && open_q == 2'b00) else $error("bus not released");
  a_lost_nondram: assert property (st_q == ST_IDLE && lost && nondram_busy
    && !bus_driven_n |=> !bus_driven_n && ras_on_q == 2'b00) else $error("nondram case");
  a_lost_idle: assert property (st_q == ST_IDLE && lost && !nondram_busy
    && !bus_driven_n |=> bus_driven_n && ras_on_q == 2'b00) else $error("idle release");
  a_lock_hold: assert property (lock_held_q && !bus_driven_n && !refresh_pend
    && st_q == ST_IDLE && !core_req.req |=> !bus_driven_n && ras_on_q == $past(ras_on_q))
    else $error("locked bus lost");

  // Pin timing of single steps
  sequence s_wr_data;
    transfer_start_n && dram_data_oe && cas_on_q != 4'h0;
  endsequence
  a_hit_read_pins: assert property (st_q == ST_HIT && !core_req.write |->
    dram_write_n && transfer_size == core_req.size
    && dram_addr == ADDR_W'(core_req.addr[10:0])) else $error("hit read pins wrong");
  a_word_write_seq: assert property (st_q == ST_HIT && core_req.write |->
    !dram_write_n && !transfer_start_n ##1 s_wr_data)
    else $error("hit write sequence wrong");
  a_ack_release: assert property (transfer_ack |=> !transfer_ack
    && cas_on_q == 4'h0)
    else $error("ack or strobe not released");
  a_col_gap_wait: assert property (!cas_zero |=>
    transfer_start_n)
    else $error("start before column precharge");
  a_other_bank: assert property (st_q == ST_IDLE && go && !open_q[b]
    && ras_zero[b] |=> !transfer_start_n)
    else $error("precharged bank delayed");
  a_ext_close: assert property (st_q == ST_ACK && core_req.ext |=>
    open_q == 2'b00)
    else $error("external page left open");
  a_miss_write_row: assert property (st_q == ST_PRE && ras_zero[b] && !lost
    |=> !transfer_start_n && dram_write_n == !core_req.write)
    else $error("miss row start wrong");
  a_data_upper: assert property (dram_data_oe |->
    dram_data_out == core_req.wdata)
    else $error("write data not on bus");
  a_row_pins: assert property (st_q == ST_ROW |->
    transfer_size == core_req.size && ras_on_q[b])
    else $error("row open pins wrong");
endmodule : fpm_dram_ctrl

// File: fpm_pkg.sv
/*
  Shared constants and carriers for the fast page mode DRAM sequencer.
  Assumes a single 50 MHz system clock and one core transfer in flight.
*/
package fpm_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W = 19;
  localparam int ROW_W = 23;
  localparam int CNT_W = 4;
  // Register byte offsets
  localparam logic [3:0] REG_CTRL_OFS = 4'h0;
  localparam logic [3:0] REG_TIMING_OFS = 4'h4;
  localparam logic [3:0] REG_STATUS_OFS = 4'h8;
  // Field positions
  localparam int CTRL_LOCK_POS = 0;
  localparam int CTRL_PSIZE_POS = 1;
  localparam int TIM_RAS_POS = 0;
  localparam int TIM_CAS_POS = 4;
  localparam int TIM_WAIT_POS = 8;
  // Reset values and timing counts in clocks
  localparam logic [CNT_W-1:0] RAS_PRE_CLK_DEF = 4'h1;
  localparam logic [CNT_W-1:0] CAS_GAP_CLK_DEF = 4'h2;
  localparam logic [CNT_W-1:0] CAS_GAP_CLK_MIN = 4'h2;
  localparam logic [CNT_W-1:0] WAIT_CLK_DEF = 4'h0;
  localparam logic [1:0] PSIZE_DEF = 2'h0;
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PRE = 6'h02,
    ST_ROW = 6'h04,
    ST_HIT = 6'h08,
    ST_COL = 6'h10,
    ST_ACK = 6'h20
  } fpm_state_e;

  typedef struct packed {
    logic req;
    logic write;
    logic bank;
    logic seq;
    logic ext;
    logic [1:0] size;
    logic [3:0] lanes;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fpm_req_s;

  typedef struct packed {
    logic [CNT_W-1:0] wait_clk;
    logic [CNT_W-1:0] cas_gap;
    logic [CNT_W-1:0] ras_pre;
    logic [1:0] page_size_code;
    logic bus_lock_bit;
  } fpm_cfg_s;
endpackage : fpm_pkg

// File: fpm_pre_cnt.sv
/*
  Precharge down counter: loads a clock count, reports when it has run out.
  Assumes the load value already accounts for the loading edge.
*/
module fpm_pre_cnt
  import fpm_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] val,
  // Status
  output logic zero
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign zero = (cnt_q == '0);
endmodule : fpm_pre_cnt

// File: fpm_dram_model.sv
/*
  Fast page mode DRAM partner: sixteen words indexed by the low address bits.
  Assumes column strobes and write strobe come straight from the sequencer.
*/
module fpm_dram_model
  import fpm_pkg::*;
(
  // DRAM pins
  input wire logic [ADDR_W-1:0] dram_addr,
  input wire logic [3:0] cas_n,
  input wire logic dram_write_n,
  input wire logic [31:0] dram_data_out,
  output logic [31:0] dram_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [16];
  logic [31:0] last;
  wire logic cas_on = ~&cas_n;
  initial begin
    last = 32'h0;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 32'h5a000000 + i;
    end
  end
  // Write data latched as a column strobe falls
  always @(posedge cas_on) begin
    if (!dram_write_n) begin
      mem[dram_addr[3:0]] = dram_data_out;
    end
  end
  always @(negedge cas_on) begin
    last = mem[dram_addr[3:0]];
  end
  // Drives only under a read strobe; a released bus shows the inverse
  always_comb begin
    if (cas_on && dram_write_n) dram_data_in = mem[dram_addr[3:0]];
    else dram_data_in = ~last;
  end
endmodule : fpm_dram_model

// File: fpm_tb.sv
/*
  Self-checking bench for the fast page mode sequencer.
  Assumes the DRAM partner model and a 50 MHz clock.
*/
module testbench
  import fpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] B0 = 32'h00012000;
  localparam logic [31:0] B1 = 32'h00034000;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, transfer_ack;
  logic bus_grant_n, nondram_busy, refresh_pend, bus_driven_n;
  logic dram_write_n, transfer_start_n, dram_data_oe, wn_ts, bd_ack, seq_b = 1'b0;
  logic [3:0] avs_address, cas_n;
  logic [1:0] ras_n, transfer_size, sz_ts;
  logic [31:0] avs_writedata, avs_readdata, core_rdata, dram_data_out, dram_data_in;
  logic [ADDR_W-1:0] dram_addr, a_ts;
  logic [31:0] sh [16];
  fpm_req_s core_req;
  int miscompares = 0, checks = 0, cyc = 0, ts_c = 0, ack_c = 0, r0_hi = 0;
  int req_c, lat, gap;

  fpm_dram_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_req(core_req),
    .transfer_ack(transfer_ack), .core_rdata(core_rdata), .bus_grant_n(bus_grant_n),
    .nondram_busy(nondram_busy), .refresh_pend(refresh_pend), .bus_driven_n(bus_driven_n),
    .dram_addr(dram_addr), .ras_n(ras_n), .cas_n(cas_n), .dram_write_n(dram_write_n),
    .transfer_size(transfer_size), .transfer_start_n(transfer_start_n),
    .dram_data_out(dram_data_out), .dram_data_oe(dram_data_oe), .dram_data_in(dram_data_in));
  fpm_dram_model u_mem (.dram_addr(dram_addr), .cas_n(cas_n), .dram_write_n(dram_write_n),
    .dram_data_out(dram_data_out), .dram_data_in(dram_data_in));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Records the cycle of start, ack and last row strobe release
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (transfer_start_n === 1'b0) begin
      ts_c <= cyc;
      a_ts <= dram_addr;
      wn_ts <= dram_write_n;
      sz_ts <= transfer_size;
    end
    if (transfer_ack === 1'b1) begin
      ack_c <= cyc;
      bd_ack <= bus_driven_n;
    end
    if (ras_n[0] !== 1'b0) r0_hi <= cyc;
  end

  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic chk_v(input logic [31:0] g, e, input string m);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_v
  task automatic chk_c(input int g, e, input string m);
    checks++;
    if (g != e) begin
      miscompares++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, m, g, e);
    end
  endtask : chk_c
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk_c(n / 20, 0, "bus timeout");
  endtask : bus
  task automatic xfer(input logic w, b, e, input logic [1:0] sz, input logic [31:0] a, d);
    int n, pa;
    pa = ack_c;
    @(posedge clk);
    core_req <= '{req: 1'b1, write: w, bank: b, seq: seq_b, ext: e, size: sz,
      lanes: (w ? 4'h3 : (sz == SIZE_BYTE ? 4'h1 : 4'hf)), addr: a, wdata: d};
    req_c = cyc + 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (transfer_ack !== 1'b1 && n < 40);
    core_req.req <= 1'b0;
    #1;
    chk_c(n / 40, 0, "ack timeout");
    gap = ts_c - pa;
    lat = ack_c - ts_c;
  endtask : xfer
  task automatic own();
    int n;
    @(posedge clk);
    bus_grant_n <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (bus_driven_n !== 1'b0 && n < 20);
  endtask : own
  task automatic lose(input logic busy);
    @(posedge clk);
    bus_grant_n <= 1'b1;
    nondram_busy <= busy;
    @(posedge clk);
    #1;
  endtask : lose

  initial begin
    #400000;
    miscompares++;
    results();
  end

  initial begin
    logic [31:0] q, dw, a;
    int ml0;
    sys_rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {nondram_busy, refresh_pend, core_req} = '0;
    bus_grant_n = 1'b1;
    void'($urandom(32'he2d8d1ac));
    for (int i = 0; i < 16; i++) sh[i] = 32'h5a000000 + i;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    bus(0, REG_CTRL_OFS, 0, q);
    chk_v(q, 32'h0, "ctrl reset");
    bus(0, REG_TIMING_OFS, 0, q);
    chk_v(q, {20'h0, WAIT_CLK_DEF, CAS_GAP_CLK_DEF, RAS_PRE_CLK_DEF}, "timing reset");
    bus(1, 4'hc, 32'hffffffff, q);
    bus(0, 4'hc, 0, q);
    chk_v(q, 32'h0, "unmapped");
    $display("test registers done");
    own();
    xfer(0, 0, 0, SIZE_LONG, B0, 0);
    chk_c(lat, 2, "open lat");
    chk_v(32'(a_ts), 32'(B0[27:9]), "row addr");
    chk_v(core_rdata, sh[0], "open data");
    for (int i = 0; i < 8; i++) begin
      a = B0 | 32'($urandom_range(15, 0));
      if ($urandom_range(1, 0)) begin
        dw = {16'($urandom), 16'h0};
        xfer(1, 0, 0, SIZE_WORD, a, dw);
        sh[a[3:0]] = dw;
        chk_c(lat, 2, "hit write lat");
        chk_v(32'({wn_ts, sz_ts}), 32'({1'b0, SIZE_WORD}), "hit write strobes");
        chk_v(32'(dram_data_oe), 32'h0, "bus released");
      end else begin
        xfer(0, 0, 0, SIZE_LONG, a, 0);
        chk_c(lat, 1, "hit read lat");
        chk_v(32'({wn_ts, sz_ts}), 32'({1'b1, SIZE_LONG}), "hit read strobes");
        chk_v(core_rdata, sh[a[3:0]], "hit data");
      end
      chk_v(32'(a_ts), 32'(a[10:0]), "column addr");
      chk_c(int'(r0_hi < ts_c - 1), 1, "row kept");
      chk_c(int'(gap >= 3), 1, "start gap");
    end
    bus(1, REG_TIMING_OFS, 32'h41, q);
    xfer(0, 0, 0, SIZE_LONG, B0, 0);
    xfer(0, 0, 0, SIZE_LONG, B0, 0);
    chk_c(int'(gap >= 5), 1, "column gap");
    bus(1, REG_TIMING_OFS, 32'h21, q);
    $display("test page hits done");
    xfer(0, 0, 0, SIZE_BYTE, B0 ^ 32'h200, 0);
    chk_c(r0_hi, ts_c - 1, "miss precharge");
    chk_c(lat, 2, "miss lat");
    chk_v(32'(sz_ts), 32'(SIZE_BYTE), "miss size");
    chk_v(32'(a_ts), 32'(B0[27:9] ^ 19'h1), "miss row");
    ml0 = ts_c - req_c;
    xfer(1, 0, 0, SIZE_WORD, B0, 32'hbeef0000);
    sh[0] = 32'hbeef0000;
    chk_c(r0_hi, ts_c - 1, "miss write");
    chk_c(lat, 2, "miss write lat");
    xfer(0, 0, 0, SIZE_LONG, B0, 0);
    chk_c(lat, 1, "hit after write");
    chk_v(core_rdata, sh[0], "write back");
    seq_b = 1'b1;
    xfer(0, 0, 0, SIZE_LONG, B0, 0);
    seq_b = 1'b0;
    chk_c(ack_c - req_c, 2, "burst segment");
    chk_c(int'(lat > 2), 1, "no start on segment");
    chk_v(core_rdata, sh[0], "segment data");
    xfer(0, 1, 0, SIZE_LONG, B1, 0);
    chk_c(int'(ts_c - req_c < ml0), 1, "other bank");
    chk_v(32'(ras_n[0]), 32'h1, "bank closed");
    bus(1, REG_CTRL_OFS, 32'h2, q);
    xfer(0, 1, 0, SIZE_LONG, B1 ^ 32'h200, 0);
    chk_c(lat, 1, "page size hit");
    xfer(0, 1, 1, SIZE_LONG, B1, 0);
    repeat (3) @(posedge clk);
    #1;
    chk_v(32'(ras_n[1]), 32'h1, "external close");
    bus(1, REG_CTRL_OFS, 32'h0, q);
    xfer(0, 0, 0, SIZE_LONG, B0, 0);
    @(posedge clk);
    refresh_pend <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_v(32'(ras_n), 32'h3, "refresh close");
    @(posedge clk);
    refresh_pend <= 1'b0;
    $display("test banks done");
    xfer(0, 0, 0, SIZE_LONG, B0, 0);
    lose(0);
    chk_v(32'({bus_driven_n, ras_n[0]}), 32'h3, "idle loss");
    own();
    xfer(0, 0, 0, SIZE_LONG, B0, 0);
    lose(1);
    chk_v(32'({bus_driven_n, ras_n[0]}), 32'h1, "busy loss");
    @(posedge clk);
    nondram_busy <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_v(32'(bus_driven_n), 32'h1, "busy release");
    own();
    fork
      xfer(0, 0, 0, SIZE_LONG, B0 ^ 32'h400, 0);
      begin
        repeat (3) @(posedge clk);
        bus_grant_n <= 1'b1;
      end
    join
    chk_v(32'({bd_ack, bus_driven_n}), 32'h1, "transfer loss");
    own();
    bus(1, REG_CTRL_OFS, 32'h1, q);
    xfer(0, 0, 0, SIZE_LONG, B0, 0);
    lose(0);
    repeat (6) @(posedge clk);
    #1;
    chk_v(32'({bus_driven_n, ras_n[0]}), 32'h0, "locked");
    $display("test arbitration done");
    results();
  end
endmodule : testbench
